// [bgd_pkg.sv]
// Package with constants and types of the buck gate drive logic.
//
// Summary of operation
// - Synchronous mode: pulse high drives high side only.
// - Synchronous mode: pulse low, low side if enabled.
// - Synchronous mode: confirm driven gate off before opposite turns on.
// - Independent mode: high side follows pulse input directly.
// - Independent mode: low side follows rectifier enable.
// - Rectifier enable low holds low side off.
// - Synchronous mode: rectifier enable high lets pulse govern low side.
// - Mid-level pulse past hold-off: both gates off.
// - Shutdown overrides mode select and rectifier enable.
// - Fault ends current cycle at once, raises flag.
// - Gate supply undervoltage: no pulses, flag held high.
package bgd_pkg;

	localparam int          BGD_CLK_PERIOD_NS = 50;
	localparam int          BGD_HOLDOFF_NS    = 250;
	localparam int          BGD_DEAD_NS       = 50;
	localparam int          BGD_HOLD_CYC      = (BGD_HOLDOFF_NS + BGD_CLK_PERIOD_NS - 1) /
	                                            BGD_CLK_PERIOD_NS;
	localparam int          BGD_DEAD_CYC      = (BGD_DEAD_NS + BGD_CLK_PERIOD_NS - 1) /
	                                            BGD_CLK_PERIOD_NS;

	localparam int          BGD_ADDR_W        = 8;
	localparam logic [7:0]  BGD_OFF_CTRL      = 8'h00;
	localparam logic [7:0]  BGD_OFF_STATUS    = 8'h04;
	localparam logic [7:0]  BGD_OFF_INT_STAT  = 8'h08;
	localparam logic [7:0]  BGD_OFF_INT_MASK  = 8'h0c;

	localparam int          BGD_CTRL_EN_BIT   = 0;
	localparam logic        BGD_CTRL_RESET    = 1'b1;
	localparam logic [2:0]  BGD_INT_RESET     = 3'h0;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_HS_ON   = 3'b001,
		ST_HS_WAIT = 3'b010,
		ST_LS_ON   = 3'b011,
		ST_LS_WAIT = 3'b100
	} bgd_state_t;

	typedef struct packed {
		logic hs;
		logic ls;
	} bgd_gate_t;

	typedef struct packed {
		logic uvlo;
		logic tristate;
		logic fault;
	} bgd_irq_t;

	typedef struct packed {
		logic [20:0] zero;
		bgd_state_t  state;
		logic        mode_sync;
		logic        uvlo;
		logic        fault;
		logic        tristate;
		logic        ls;
		logic        hs;
		logic        drive_en;
		logic        mid_level;
	} bgd_status_t;

endpackage : bgd_pkg

// [bgd_tristate_detect.sv]
// Mid-level hold-off detector for the pulse-width input.
`timescale 1ns/1ps
module bgd_tristate_detect import bgd_pkg::*; #(
	parameter int HOLD_CYC = BGD_HOLD_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pulse input qualifiers
	input  wire logic mid_level,
	input  wire logic pwm_in,
	// Shutdown state
	output logic      tristate
);

	localparam int CNT_W = $clog2(HOLD_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(HOLD_CYC);

	logic [CNT_W-1:0] cnt;

	// The hold-off needs at least one cycle.
	if (HOLD_CYC < 1) begin : g_hold_check
		$error("HOLD_CYC must be at least one");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= '0;
		else if (!mid_level || tristate)
			cnt <= '0;
		else if (cnt != CNT_MAX)
			cnt <= cnt + 1'b1;
	end

	// Shutdown is left only once the controller drives a clean low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tristate <= 1'b0;
		else if (!tristate && mid_level && cnt == CNT_MAX)
			tristate <= 1'b1;
		else if (tristate && !mid_level && !pwm_in)
			tristate <= 1'b0;
	end

	chk_tristate_holdoff: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tristate) |-> $past(mid_level) && $past(cnt) == CNT_MAX)
		else $error("Shutdown entered without full mid-level hold-off.");

endmodule : bgd_tristate_detect

// [bgd_gate_drive.sv]
// Top of the buck gate drive logic with its APB register file.
`timescale 1ns/1ps
module bgd_gate_drive import bgd_pkg::*; #(
	parameter int HOLD_CYC = BGD_HOLD_CYC,
	parameter int DEAD_CYC = BGD_DEAD_CYC
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [BGD_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Controller inputs
	input  wire logic                  pwm_in,
	input  wire logic                  pwm_mid_level,
	input  wire logic                  sync_rect_enable,
	input  wire logic                  drive_mode_select,
	// Protection and gate feedback
	input  wire logic                  fault_detect,
	input  wire logic                  gate_supply_low,
	input  wire logic                  high_side_gate_off_sense,
	input  wire logic                  low_side_gate_off_sense,
	// Gate commands and flags
	output logic                       high_side_gate,
	output logic                       low_side_gate,
	output logic                       fault_flag,
	output logic                       irq
);

	localparam int DT_W = $clog2(DEAD_CYC + 1);
	localparam logic [DT_W-1:0] DT_MAX = DT_W'(DEAD_CYC);

	// The dead-time wait needs at least one cycle.
	if (DEAD_CYC < 1) begin : g_dead_check
		$error("DEAD_CYC must be at least one");
	end

	function automatic logic reg_hit(input logic [BGD_ADDR_W-1:0] addr,
	                                 input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	bgd_state_t  state;
	bgd_state_t  next_state;
	bgd_gate_t   next_gate;
	bgd_irq_t    int_stat;
	bgd_irq_t    int_mask;
	bgd_irq_t    events;
	bgd_irq_t    next_int_stat;
	bgd_status_t status_word;
	logic [DT_W-1:0] dt_cnt;
	logic        dt_done;
	logic        drive_en;
	logic        tristate;
	logic        tristate_q;
	logic        uvlo_q;
	logic        fault_latch;
	logic        next_fault_latch;
	logic        trunc;
	logic        pwm_eff;
	logic        block;
	logic        setup_done;
	logic        access;
	logic        mapped;
	logic [31:0] read_value;

	bgd_tristate_detect #(
		.HOLD_CYC (HOLD_CYC)
	) u_tristate (
		.pclk      (pclk),
		.presetn   (presetn),
		.mid_level (pwm_mid_level),
		.pwm_in    (pwm_in),
		.tristate  (tristate)
	);

	// A fault cuts the high-side pulse at once and keeps it cut until the
	// controller ends the cycle by taking the pulse input low.
	always_comb begin
		next_fault_latch = fault_latch;
		if (fault_detect)
			next_fault_latch = 1'b1;
		else if (!pwm_in)
			next_fault_latch = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_latch <= 1'b0;
		else
			fault_latch <= next_fault_latch;
	end

	assign trunc   = fault_detect | fault_latch;
	assign pwm_eff = pwm_in & ~trunc;
	assign block   = tristate | gate_supply_low | ~drive_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_flag <= 1'b0;
		else
			fault_flag <= next_fault_latch | gate_supply_low;
	end

	// Dead-time counter runs only while waiting for a gate to be seen off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dt_cnt <= '0;
		else if (state != ST_HS_WAIT && state != ST_LS_WAIT)
			dt_cnt <= '0;
		else if (!dt_done)
			dt_cnt <= dt_cnt + 1'b1;
	end

	assign dt_done = (dt_cnt == DT_MAX);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (!block && drive_mode_select) begin
					if (pwm_eff && low_side_gate_off_sense)
						next_state = ST_HS_ON;
					else if (!pwm_eff && sync_rect_enable && high_side_gate_off_sense)
						next_state = ST_LS_ON;
				end
			end
			ST_HS_ON: begin
				if (block || !drive_mode_select || !pwm_eff)
					next_state = ST_HS_WAIT;
			end
			ST_HS_WAIT: begin
				if (high_side_gate_off_sense && dt_done)
					next_state = ST_IDLE;
			end
			ST_LS_ON: begin
				if (block || !drive_mode_select || pwm_eff || !sync_rect_enable)
					next_state = ST_LS_WAIT;
			end
			ST_LS_WAIT: begin
				if (low_side_gate_off_sense && dt_done)
					next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Gate commands come from the state machine in synchronous mode and
	// straight from the inputs in independent mode.
	always_comb begin
		next_gate = '0;
		if (drive_mode_select) begin
			next_gate.hs = (next_state == ST_HS_ON);
			next_gate.ls = (next_state == ST_LS_ON);
		end else begin
			next_gate.hs = pwm_eff & ~block;
			next_gate.ls = sync_rect_enable & ~block;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_gate <= 1'b0;
			low_side_gate  <= 1'b0;
		end else begin
			high_side_gate <= next_gate.hs;
			low_side_gate  <= next_gate.ls;
		end
	end

	// Interrupt event sources.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tristate_q <= 1'b0;
			uvlo_q     <= 1'b0;
		end else begin
			tristate_q <= tristate;
			uvlo_q     <= gate_supply_low;
		end
	end

	assign events.fault    = fault_detect & ~fault_latch;
	assign events.tristate = tristate & ~tristate_q;
	assign events.uvlo     = gate_supply_low & ~uvlo_q;

	// APB: one wait state, pready is a one-cycle pulse.
	assign setup_done = psel & penable & ~pready;
	assign access     = psel & penable & pready;
	assign mapped     = reg_hit(paddr, BGD_OFF_CTRL) | reg_hit(paddr, BGD_OFF_STATUS) |
	                    reg_hit(paddr, BGD_OFF_INT_STAT) | reg_hit(paddr, BGD_OFF_INT_MASK);

	// A new event wins over a write-one-to-clear in the same cycle.
	always_comb begin
		next_int_stat = int_stat | events;
		if (access && pwrite && reg_hit(paddr, BGD_OFF_INT_STAT))
			next_int_stat = (int_stat & ~bgd_irq_t'(pwdata[2:0])) | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_stat <= BGD_INT_RESET;
		else
			int_stat <= next_int_stat;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(next_int_stat & int_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_en <= BGD_CTRL_RESET;
			int_mask <= BGD_INT_RESET;
		end else if (access && pwrite) begin
			if (reg_hit(paddr, BGD_OFF_CTRL))
				drive_en <= pwdata[BGD_CTRL_EN_BIT];
			else if (reg_hit(paddr, BGD_OFF_INT_MASK))
				int_mask <= bgd_irq_t'(pwdata[2:0]);
		end
	end

	always_comb begin
		status_word           = '0;
		status_word.state     = state;
		status_word.mode_sync = drive_mode_select;
		status_word.uvlo      = gate_supply_low;
		status_word.fault     = fault_flag;
		status_word.tristate  = tristate;
		status_word.ls        = low_side_gate;
		status_word.hs        = high_side_gate;
		status_word.drive_en  = drive_en;
		status_word.mid_level = pwm_mid_level;
	end

	always_comb begin
		read_value = '0;
		if (reg_hit(paddr, BGD_OFF_CTRL))
			read_value = {31'h0, drive_en};
		else if (reg_hit(paddr, BGD_OFF_STATUS))
			read_value = status_word;
		else if (reg_hit(paddr, BGD_OFF_INT_STAT))
			read_value = {29'h0, int_stat};
		else if (reg_hit(paddr, BGD_OFF_INT_MASK))
			read_value = {29'h0, int_mask};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup_done;
			pslverr <= setup_done & ~mapped;
			prdata  <= (setup_done && !pwrite) ? read_value : 32'h0;
		end
	end

	chk_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
		drive_mode_select |-> !(high_side_gate && low_side_gate))
		else $error("Both gates on in synchronous mode.");

	chk_sync_hs_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(drive_mode_select && high_side_gate) |-> $past(pwm_eff) && !low_side_gate)
		else $error("High side on without a pulse.");

	chk_sync_ls_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(drive_mode_select && low_side_gate) |-> !$past(pwm_eff) && !high_side_gate)
		else $error("Low side on while pulse high.");

	chk_sync_ls_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$past(drive_mode_select && !sync_rect_enable) |-> !low_side_gate)
		else $error("Low side on with rectifier disabled.");

	chk_sync_ls_enable: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && state == ST_IDLE && drive_mode_select && sync_rect_enable && !pwm_eff &&
		 high_side_gate_off_sense && !block) |=> low_side_gate)
		else $error("Low side did not switch on when enabled.");

	chk_indep_hs_follow: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn && !drive_mode_select && !block) |-> high_side_gate == $past(pwm_eff))
		else $error("High side does not follow pulse in independent mode.");

	chk_indep_ls_follow: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn && !drive_mode_select && !block) |->
		low_side_gate == $past(sync_rect_enable))
		else $error("Low side does not follow enable in independent mode.");

	chk_shutdown_off: assert property (@(posedge pclk) disable iff (!presetn)
		tristate |=> !high_side_gate && !low_side_gate)
		else $error("Gate on during shutdown.");

	chk_fault_cut: assert property (@(posedge pclk) disable iff (!presetn)
		fault_detect |=> !high_side_gate && fault_flag)
		else $error("Fault did not end the cycle.");

	chk_uvlo_hold: assert property (@(posedge pclk) disable iff (!presetn)
		gate_supply_low |=> fault_flag && !high_side_gate && !low_side_gate)
		else $error("Gate pulse or no flag under undervoltage.");

	chk_apb_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("APB ready not a single pulse after one wait.");

endmodule : bgd_gate_drive

// [bgd_ctrl_model.sv]
// Controller and power stage model that faces the gate drive logic.
`timescale 1ns/1ps
module bgd_ctrl_model (
	// Clock and mode
	input  wire logic pclk,
	input  wire logic mode_sync,
	// Gate commands seen by the power stage
	input  wire logic high_side_gate,
	input  wire logic low_side_gate,
	// Controller pins
	output logic      pwm_in,
	output logic      pwm_mid_level,
	output logic      sync_rect_enable,
	// Gate off feedback
	output logic      high_side_gate_off_sense,
	output logic      low_side_gate_off_sense
);
	int   lag = 0;
	int   hs_off = 15;
	int   ls_off = 15;
	logic floating = 1'b0;

	initial begin
		pwm_in = 1'b0;
		pwm_mid_level = 1'b0;
		sync_rect_enable = 1'b0;
	end

	// A gate reads as off only after it has been low for more than lag cycles.
	assign high_side_gate_off_sense = hs_off > lag;
	assign low_side_gate_off_sense = ls_off > lag;

	always @(posedge pclk) begin
		hs_off <= high_side_gate ? 0 : (hs_off < 15 ? hs_off + 1 : 15);
		ls_off <= low_side_gate ? 0 : (ls_off < 15 ? ls_off + 1 : 15);
		// A released pin sits mid-band; it reads low so it never overlaps the enable.
		if (floating)
			pwm_in <= 1'b0;
	end

	task automatic drive(input logic p, input logic s);
		@(posedge pclk);
		pwm_in <= p;
		sync_rect_enable <= (!mode_sync && p) ? 1'b0 : s;
	endtask : drive

	task automatic release_pin();
		@(posedge pclk);
		floating <= 1'b1;
		pwm_mid_level <= 1'b1;
	endtask : release_pin

	task automatic retake_pin();
		@(posedge pclk);
		floating <= 1'b0;
		@(posedge pclk);
		pwm_in <= 1'b0;
		pwm_mid_level <= 1'b0;
	endtask : retake_pin
endmodule : bgd_ctrl_model

// [buck_gate_drive_logic_test.sv]
// Self-checking testbench of the buck gate drive logic.
`timescale 1ns/1ps
module buck_gate_drive_logic_test;
	import bgd_pkg::*;
	localparam int         HOLD = 2;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [BGD_ADDR_W-1:0] paddr = '0;
	logic [31:0]           pwdata = '0;
	logic [31:0]           prdata;
	logic                  pready, pslverr, irq, fault_flag;
	logic                  pwm_in, pwm_mid_level, sync_rect_enable;
	logic                  high_side_gate_off_sense, low_side_gate_off_sense;
	logic                  high_side_gate, low_side_gate;
	logic                  drive_mode_select = 1'b1;
	logic                  fault_detect = 1'b0;
	logic                  gate_supply_low = 1'b0;
	logic [31:0]           rd;
	logic                  err;
	int                    miscompares = 0;
	int                    cmp_count = 0;

	always #25 pclk = ~pclk;

	bgd_gate_drive #(.HOLD_CYC(HOLD), .DEAD_CYC(1)) DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_in, .pwm_mid_level,
		.sync_rect_enable, .drive_mode_select, .fault_detect, .gate_supply_low,
		.high_side_gate_off_sense, .low_side_gate_off_sense, .high_side_gate, .low_side_gate,
		.fault_flag, .irq);

	bgd_ctrl_model ctl (.pclk, .mode_sync(drive_mode_select), .high_side_gate,
		.low_side_gate, .pwm_in, .pwm_mid_level, .sync_rect_enable, .high_side_gate_off_sense,
		.low_side_gate_off_sense);

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	always @(negedge pclk)
		if (presetn === 1'b1 && high_side_gate === 1'b1)
			check("gate overlap", low_side_gate, 1'b0);

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("apb answer", pready, 1'b1);
		if (pready !== 1'b1)
			give_verdict();
	endtask : apb

	task automatic after1(input logic hs, input logic ls);
		@(posedge pclk);
		#1;
		check("gates next cycle", {high_side_gate, low_side_gate}, {hs, ls});
	endtask : after1

	task automatic wait_gates(input logic hs, input logic ls, input int max);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while ({high_side_gate, low_side_gate} !== {hs, ls} && n < max);
		check("gates", {high_side_gate, low_side_gate}, {hs, ls});
		if ({high_side_gate, low_side_gate} !== {hs, ls})
			give_verdict();
	endtask : wait_gates

	task automatic do_reset(input logic mode);
		@(posedge pclk);
		presetn <= 1'b0;
		drive_mode_select <= mode;
		repeat (12) @(posedge pclk);
		check("gates in reset", {high_side_gate, low_side_gate}, 2'b00);
		presetn <= 1'b1;
	endtask : do_reset

	task automatic t_regs();
		do_reset(1'b1);
		apb(1'b0, BGD_OFF_CTRL, '0);
		check("ctrl reset", rd, 32'h1);
		apb(1'b0, BGD_OFF_INT_MASK, '0);
		check("mask reset", rd, 32'h0);
		apb(1'b0, BGD_OFF_STATUS, '0);
		check("status reset", rd, 32'h82);
		apb(1'b0, 8'h10, '0);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_sync();
		ctl.drive(1'b1, 1'b1);
		wait_gates(1'b1, 1'b0, 6);
		ctl.drive(1'b0, 1'b1);
		wait_gates(1'b0, 1'b1, 8);
		ctl.drive(1'b0, 1'b0);
		wait_gates(1'b0, 1'b0, 6);
		ctl.drive(1'b1, 1'b0);
		wait_gates(1'b1, 1'b0, 6);
		ctl.lag = 4;
		ctl.drive(1'b0, 1'b0);
		repeat (8) @(posedge pclk);
		check("ls held off", low_side_gate, 1'b0);
		ctl.drive(1'b1, 1'b1);
		wait_gates(1'b1, 1'b0, 12);
		ctl.drive(1'b0, 1'b1);
		wait_gates(1'b0, 1'b0, 4);
		repeat (3) @(posedge pclk);
		check("ls waits for off sense", low_side_gate, 1'b0);
		wait_gates(1'b0, 1'b1, 12);
		ctl.lag = 0;
		apb(1'b1, BGD_OFF_CTRL, 32'h0);
		wait_gates(1'b0, 1'b0, 6);
		apb(1'b1, BGD_OFF_CTRL, 32'h1);
		wait_gates(1'b0, 1'b1, 8);
		$display("test sync done");
	endtask : t_sync

	task automatic t_indep();
		do_reset(1'b0);
		ctl.drive(1'b1, 1'b0);
		after1(1'b1, 1'b0);
		ctl.drive(1'b0, 1'b1);
		after1(1'b0, 1'b1);
		ctl.drive(1'b0, 1'b0);
		after1(1'b0, 1'b0);
		ctl.drive(1'b0, 1'b1);
		after1(1'b0, 1'b1);
		$display("test indep done");
	endtask : t_indep

	task automatic t_tristate();
		apb(1'b1, BGD_OFF_INT_MASK, 32'h2);
		ctl.release_pin();
		repeat (HOLD) @(posedge pclk);
		#1;
		check("not before hold-off", low_side_gate, 1'b1);
		wait_gates(1'b0, 1'b0, 4);
		@(posedge pclk);
		#1;
		check("irq on entry", irq, 1'b1);
		apb(1'b0, BGD_OFF_INT_STAT, '0);
		check("entry status", rd, 32'h2);
		apb(1'b1, BGD_OFF_INT_STAT, 32'h2);
		@(posedge pclk);
		#1;
		check("irq cleared", irq, 1'b0);
		check("gates in shutdown", {high_side_gate, low_side_gate}, 2'b00);
		ctl.retake_pin();
		wait_gates(1'b0, 1'b1, 8);
		$display("test tristate done");
	endtask : t_tristate

	task automatic t_fault();
		do_reset(1'b1);
		apb(1'b1, BGD_OFF_INT_MASK, 32'h2);
		ctl.drive(1'b1, 1'b1);
		wait_gates(1'b1, 1'b0, 6);
		@(posedge pclk);
		fault_detect <= 1'b1;
		after1(1'b0, 1'b0);
		check("fault flag", fault_flag, 1'b1);
		@(posedge pclk);
		fault_detect <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		check("cycle stays cut", high_side_gate, 1'b0);
		check("masked irq", irq, 1'b0);
		apb(1'b0, BGD_OFF_INT_STAT, '0);
		check("fault status", rd, 32'h1);
		ctl.drive(1'b0, 1'b1);
		wait_gates(1'b0, 1'b1, 8);
		ctl.drive(1'b1, 1'b1);
		wait_gates(1'b1, 1'b0, 8);
		@(posedge pclk);
		gate_supply_low <= 1'b1;
		after1(1'b0, 1'b0);
		repeat (4) @(posedge pclk);
		#1;
		check("uvlo gates and flag", {high_side_gate, low_side_gate, fault_flag}, 3'b001);
		$display("test fault done");
	endtask : t_fault

	initial begin
		t_regs();
		t_sync();
		t_indep();
		t_tristate();
		t_fault();
		give_verdict();
	end
endmodule : buck_gate_drive_logic_test
